// >>> hw/alu_params.svh
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH

`define DATA_W        8
`define NIB_W         4
`define ADDR_W_DEF    8
`define WREG_RESET    8'h00
`define FLAGS_RESET   4'h0
`define FLAG_BORROW   0
`define FLAG_HALF     1
`define FLAG_NULL     2
`define FLAG_WRAP     3
`define FLAGS_W       4

`endif

// >>> hw/alu_pkg.sv
package alu_pkg;

  typedef enum logic [4:0] {
    OP_NONE     = 5'b00001,
    OP_SUB_MEM  = 5'b00010,
    OP_SUB_TOM  = 5'b00100,
    OP_SUB_IMM  = 5'b01000,
    OP_SWAP     = 5'b10000
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } state_t;

endpackage : alu_pkg

// >>> hw/data_ram.sv
`timescale 1ns/1ps
`default_nettype none
`include "alu_params.svh"

module data_ram #(
  parameter int ADDR_W = `ADDR_W_DEF
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_we,
  input  wire logic [ADDR_W-1:0]    i_addr,
  input  wire logic [`DATA_W-1:0]   i_wdata,
  output logic      [`DATA_W-1:0]   o_rdata
);

  logic [`DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [`DATA_W-1:0] rdata_q;

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    rdata_q <= mem[i_addr];
  end

  assign o_rdata = rdata_q;

endmodule : data_ram
`default_nettype wire

// >>> hw/subtract_and_nibble_swap_alu.sv
// Function
// - register-minus-memory puts working_register minus the memory byte in working_register.
// - minus_to_memory_op writes working_register minus the byte back to it, register kept.
// - immediate subtract puts working_register minus the instruction constant in it.
// - every subtract clears borrow-out when negative and sets it when zero or positive.
// - nibble swap exchanges the two nibbles of the memory byte and writes it back.
`timescale 1ns/1ps
`default_nettype none
`include "alu_params.svh"

module subtract_and_nibble_swap_alu #(
  parameter int ADDR_W = `ADDR_W_DEF
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_start,
  input  wire alu_pkg::op_t         i_op,
  input  wire logic [ADDR_W-1:0]    i_addr,
  input  wire logic [`DATA_W-1:0]   i_imm,
  input  wire logic                 i_wr_load,
  input  wire logic [`DATA_W-1:0]   i_wr_data,
  output logic                      o_busy,
  output logic                      o_done,
  output logic [`DATA_W-1:0]        o_working_register,
  output logic                      o_signed_wrap_flag,
  output logic                      o_null_flag,
  output logic                      o_half_borrow_flag,
  output logic                      o_borrow_out_flag
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // subtract with flags
  // ----------------------------------------------------------------
  function automatic logic [`DATA_W+`FLAGS_W-1:0] sub_flags(
    input logic [`DATA_W-1:0] a,
    input logic [`DATA_W-1:0] b
  );
    logic [`DATA_W:0]   full;
    logic [`NIB_W:0]    low;
    logic [`DATA_W-1:0] diff;
    logic [`FLAGS_W-1:0] f;
    full = {1'b0, a} - {1'b0, b};
    low  = {1'b0, a[`NIB_W-1:0]} - {1'b0, b[`NIB_W-1:0]};
    diff = full[`DATA_W-1:0];
    f[`FLAG_BORROW] = ~full[`DATA_W];
    f[`FLAG_HALF]   = ~low[`NIB_W];
    f[`FLAG_NULL]   = (diff == '0);
    f[`FLAG_WRAP]   = (a[`DATA_W-1] ^ b[`DATA_W-1]) & (a[`DATA_W-1] ^ diff[`DATA_W-1]);
    return {diff, f};
  endfunction : sub_flags

  // ----------------------------------------------------------------
  // memory
  // ----------------------------------------------------------------
  logic               mem_we;
  logic [`DATA_W-1:0] mem_wdata;
  logic [`DATA_W-1:0] mem_rdata;
  logic [ADDR_W-1:0]  addr_q;
  logic [ADDR_W-1:0]  addr_d;

  data_ram #(
    .ADDR_W (ADDR_W)
  ) u_ram (
    .i_mclk  (i_mclk),
    .i_we    (mem_we),
    .i_addr  (addr_d),
    .i_wdata (mem_wdata),
    .o_rdata (mem_rdata)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  alu_pkg::state_t     state_q, state_d;
  alu_pkg::op_t        op_q, op_d;
  logic [`DATA_W-1:0]  imm_q, imm_d;
  logic [`DATA_W-1:0]  wreg_q, wreg_d;
  logic [`FLAGS_W-1:0] flags_q, flags_d;
  logic                done_q, done_d;
  logic [`DATA_W+`FLAGS_W-1:0] res;
  logic [`DATA_W-1:0]  swapped;

  always_comb begin
    state_d   = state_q;
    op_d      = op_q;
    imm_d     = imm_q;
    addr_d    = addr_q;
    wreg_d    = wreg_q;
    flags_d   = flags_q;
    done_d    = 1'b0;
    mem_we    = 1'b0;
    res       = sub_flags(wreg_q, mem_rdata);
    swapped   = {mem_rdata[`NIB_W-1:0], mem_rdata[`DATA_W-1:`NIB_W]};
    mem_wdata = res[`DATA_W+`FLAGS_W-1:`FLAGS_W];
    case (state_q)
      alu_pkg::ST_IDLE: begin
        if (i_wr_load) begin
          wreg_d = i_wr_data;
        end
        if (i_start) begin
          op_d  = i_op;
          imm_d = i_imm;
          if (i_op == alu_pkg::OP_SUB_IMM) begin
            res     = sub_flags(wreg_q, i_imm);
            wreg_d  = res[`DATA_W+`FLAGS_W-1:`FLAGS_W];
            flags_d = res[`FLAGS_W-1:0];
            done_d  = 1'b1;
          end else if (i_op != alu_pkg::OP_NONE) begin
            addr_d  = i_addr;
            state_d = alu_pkg::ST_READ;
          end
        end
      end
      alu_pkg::ST_READ: begin
        state_d = alu_pkg::ST_WRITE;
      end
      alu_pkg::ST_WRITE: begin
        state_d = alu_pkg::ST_IDLE;
        done_d  = 1'b1;
        case (op_q)
          alu_pkg::OP_SUB_MEM: begin
            wreg_d  = res[`DATA_W+`FLAGS_W-1:`FLAGS_W];
            flags_d = res[`FLAGS_W-1:0];
          end
          alu_pkg::OP_SUB_TOM: begin
            mem_we  = 1'b1;
            flags_d = res[`FLAGS_W-1:0];
          end
          alu_pkg::OP_SWAP: begin
            mem_we    = 1'b1;
            mem_wdata = swapped;
          end
          default: begin
          end
        endcase
      end
      default: begin
        state_d = alu_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= alu_pkg::ST_IDLE;
      op_q    <= alu_pkg::OP_NONE;
      imm_q   <= '0;
      addr_q  <= '0;
      wreg_q  <= `WREG_RESET;
      flags_q <= `FLAGS_RESET;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      imm_q   <= imm_d;
      addr_q  <= addr_d;
      wreg_q  <= wreg_d;
      flags_q <= flags_d;
      done_q  <= done_d;
    end
  end

  assign o_busy             = (state_q != alu_pkg::ST_IDLE);
  assign o_done             = done_q;
  assign o_working_register = wreg_q;
  assign o_signed_wrap_flag = flags_q[`FLAG_WRAP];
  assign o_null_flag        = flags_q[`FLAG_NULL];
  assign o_half_borrow_flag = flags_q[`FLAG_HALF];
  assign o_borrow_out_flag  = flags_q[`FLAG_BORROW];

endmodule : subtract_and_nibble_swap_alu
`default_nettype wire

// >>> sim/alu_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "alu_params.svh"
module alu_monitor (
  input wire logic               i_mclk,
  input wire logic               i_resetn,
  input wire logic               i_start,
  input wire alu_pkg::op_t       i_op,
  input wire logic [`DATA_W-1:0] i_imm,
  input wire logic               o_busy,
  input wire logic               o_done,
  input wire logic [`DATA_W-1:0] o_working_register,
  input wire logic               o_signed_wrap_flag,
  input wire logic               o_null_flag,
  input wire logic               o_half_borrow_flag,
  input wire logic               o_borrow_out_flag
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  wire logic       go = i_start && !o_busy;
  wire logic [7:0] w  = o_working_register;
  wire logic [3:0] lo = o_working_register[3:0];
  wire logic [3:0] il = i_imm[3:0];
  wire logic [3:0] f  = {o_signed_wrap_flag, o_null_flag, o_half_borrow_flag, o_borrow_out_flag};
  a_imm_diff: assert property (go && i_op == alu_pkg::OP_SUB_IMM |=> o_done && w == $past(w) - $past(i_imm))
    else $error("immediate difference wrong");
  a_imm_borrows: assert property (go && i_op == alu_pkg::OP_SUB_IMM |=>
    o_borrow_out_flag == ($past(w) >= $past(i_imm)) && o_half_borrow_flag == ($past(lo) >= $past(il)))
    else $error("immediate borrow flags wrong");
  a_null_wrap: assert property (go && i_op == alu_pkg::OP_SUB_IMM |=> o_null_flag == (w == 8'h00) &&
    o_signed_wrap_flag == ($past(w[7]) != $past(i_imm[7]) && w[7] != $past(w[7])))
    else $error("null or wrap flag wrong");
  a_mem_borrow: assert property (go && i_op == alu_pkg::OP_SUB_MEM |-> ##3 o_done &&
    o_borrow_out_flag == (w <= $past(w, 3)) && o_null_flag == (w == 8'h00))
    else $error("memory subtract flags wrong");
  a_tom_keep: assert property (go && i_op == alu_pkg::OP_SUB_TOM |-> ##3 o_done && w == $past(w, 3))
    else $error("working register changed");
  a_swap_flags: assert property (go && i_op == alu_pkg::OP_SWAP |-> ##3 o_done && f == $past(f, 3))
    else $error("swap touched flags");
endmodule : alu_monitor
bind subtract_and_nibble_swap_alu alu_monitor u_mon (.i_mclk, .i_resetn, .i_start, .i_op, .i_imm,
  .o_busy, .o_done, .o_working_register, .o_signed_wrap_flag, .o_null_flag, .o_half_borrow_flag,
  .o_borrow_out_flag);
`default_nettype wire

// >>> sim/subtract_and_nibble_swap_alu_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "alu_params.svh"
module subtract_and_nibble_swap_alu_tb;
  logic         i_mclk = 1'h0, i_resetn = 1'h0, i_start = 1'h0, i_wr_load = 1'h0;
  alu_pkg::op_t i_op = alu_pkg::OP_NONE;
  logic [7:0]   i_addr = 8'h05, i_imm = 8'h00, i_wr_data = 8'h00, m;
  logic [11:0]  e;
  logic         o_busy, o_done, o_signed_wrap_flag, o_null_flag, o_half_borrow_flag;
  logic         o_borrow_out_flag;
  logic [7:0]   o_working_register;
  wire logic [11:0] res = {o_signed_wrap_flag, o_null_flag, o_half_borrow_flag,
    o_borrow_out_flag, o_working_register};
  int error_cnt = 0, checked = 0;
  // working value, immediate, expected flags and result
  logic [27:0] rows [5] = '{28'h5030320, 28'h30502e0, 28'h4444700, 28'h800197f, 28'h7fffa80};
  subtract_and_nibble_swap_alu u_dut (.i_mclk, .i_resetn, .i_start, .i_op, .i_addr, .i_imm,
    .i_wr_load, .i_wr_data, .o_busy, .o_done, .o_working_register, .o_signed_wrap_flag,
    .o_null_flag, .o_half_borrow_flag, .o_borrow_out_flag);
  function automatic logic [11:0] ex(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = a - b;
    return {a[7] != b[7] && d[7] != a[7], d == 8'h00, a[3:0] >= b[3:0], a >= b, d};
  endfunction : ex
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  task automatic run(input alu_pkg::op_t op, input logic [7:0] w, input logic [7:0] x);
    @(posedge i_mclk);
    i_wr_load <= 1'h1;
    i_wr_data <= w;
    @(posedge i_mclk);
    i_wr_load <= 1'h0;
    i_start <= 1'h1;
    i_op <= op;
    i_imm <= x;
    @(posedge i_mclk);
    i_start <= 1'h0;
    @(negedge i_mclk);
    chk({11'h000, o_busy | o_done}, 12'h001);
    for (int n = 0; n < 4 && o_done !== 1'h1; n++) @(negedge i_mclk);
    chk({11'h000, o_done}, 12'h001);
  endtask : run
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  initial forever #12.5 i_mclk = ~i_mclk;
  initial begin
    #10000;
    error_cnt++;
    stop_test;
  end
  initial begin
    // known byte at the test address, the memory has no reset
    m = 8'h5a;
    u_dut.u_ram.mem[8'h05] = m;
    repeat (5) @(posedge i_mclk);
    chk(res, 12'h000);
    i_resetn <= 1'h1;
    repeat (3) @(posedge i_mclk);
    foreach (rows[k]) begin
      run(alu_pkg::OP_SUB_IMM, rows[k][27:20], rows[k][19:12]);
      chk(res, rows[k][11:0]);
    end
    run(alu_pkg::OP_SUB_MEM, 8'h00, 8'h00);
    chk({11'h000, $isunknown(res)}, 12'h000);
    chk(res, ex(8'h00, m));
    run(alu_pkg::OP_SUB_TOM, 8'h3c, 8'h00);
    e = ex(8'h3c, m);
    chk(res, {e[11:8], 8'h3c});
    m = 8'h3c - m;
    run(alu_pkg::OP_SWAP, 8'h3c, 8'h00);
    chk(res, {e[11:8], 8'h3c});
    run(alu_pkg::OP_SUB_MEM, 8'h3c, 8'h00);
    chk(res, ex(8'h3c, {m[3:0], m[7:4]}));
    // no operation code: no done pulse
    @(posedge i_mclk);
    i_start <= 1'h1;
    i_op <= alu_pkg::OP_NONE;
    @(posedge i_mclk);
    i_start <= 1'h0;
    repeat (4) begin
      @(negedge i_mclk);
      chk({11'h000, o_done | o_busy}, 12'h000);
    end
    // reset while idle
    @(posedge i_mclk);
    i_resetn <= 1'h0;
    @(negedge i_mclk);
    chk(res, 12'h000);
    chk({11'h000, o_done | o_busy}, 12'h000);
    @(posedge i_mclk);
    i_resetn <= 1'h1;
    repeat (3) @(posedge i_mclk);
    run(alu_pkg::OP_SUB_IMM, rows[0][27:20], rows[0][19:12]);
    chk(res, rows[0][11:0]);
    stop_test;
  end
endmodule : subtract_and_nibble_swap_alu_tb
`default_nettype wire
